// ---- rtl/mtcc_pkg.sv ----
// Constants, types and helper functions for the modem test and call control block
package mtcc_pkg;

  // Timing: system clock and the clock output target (twice the crystal rate)
  localparam longint unsigned CLK_HZ = 40_000_000;
  localparam longint unsigned XTAL_HZ = 4_915_200;
  localparam longint unsigned CLOCK_OUTPUT_PIN_HZ = XTAL_HZ * 2;
  localparam logic [31:0] CLOCK_OUTPUT_PIN_INC = 32'((CLOCK_OUTPUT_PIN_HZ << 32) / CLK_HZ);

  // Register numbers as given after the S in a command
  localparam logic [7:0] REG_SPEED = 8'h07;
  localparam logic [7:0] REG_ALERT = 8'hE2;
  localparam logic [7:0] REG_MODCTL = 8'hE5;
  localparam logic [7:0] REG_PATTERN = 8'hE6;
  localparam logic [7:0] REG_DSPMODE = 8'hE8;
  localparam logic [7:0] REG_DAACTL = 8'hF1;
  localparam logic [7:0] REG_DAASTAT = 8'hF2;
  localparam logic [7:0] REG_LINEINFO = 8'hF8;

  // Field positions
  localparam int HYB_BIT = 2;
  localparam int LINK_BIT = 3;
  localparam int REV_LSB = 4;
  localparam int MOD_TX_BIT = 0;
  localparam int MOD_QAM_BIT = 2;
  localparam int MOD_ORIG_BIT = 3;
  localparam int MOD_G550_BIT = 4;
  localparam int MOD_G1800_BIT = 5;

  // Values with a meaning
  localparam logic [7:0] DSP_MODE_TEST = 8'h05;
  localparam logic [7:0] ALERT_ENABLE_VAL = 8'hC0;
  localparam logic [7:0] SPEED_QAM2400 = 8'h06;
  localparam logic [7:0] SPEED_DPSK1200 = 8'h02;
  localparam logic [7:0] SPEED_FSK300 = 8'h01;

  // Reset values
  localparam logic [7:0] DAACTL_RST = 8'h04;
  localparam logic [7:0] SPEED_RST = 8'h06;
  localparam logic [7:0] DSPMODE_RST = 8'h00;
  localparam logic [7:0] ALERT_RST = 8'h00;
  localparam logic [7:0] PATTERN_RST = 8'h00;

  // Command characters
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_T = 8'h54;
  localparam logic [7:0] CH_S = 8'h53;
  localparam logic [7:0] CH_EQ = 8'h3D;
  localparam logic [7:0] CH_QUERY = 8'h3F;
  localparam logic [7:0] CH_CR = 8'h0D;

  // Progress characters
  localparam logic [7:0] CH_DIAL_TONE = 8'h74;
  localparam logic [7:0] CH_DIALED = 8'h2C;
  localparam logic [7:0] CH_RINGBACK = 8'h72;
  localparam logic [7:0] CH_BUSY = 8'h62;
  localparam logic [7:0] CH_NO_CARRIER = 8'h4E;
  localparam logic [7:0] CH_CONNECT = 8'h63;
  localparam logic [7:0] CH_CONNECT_1200 = 8'h64;

  typedef enum logic [2:0] {
    EV_DIAL_TONE = 3'h0,
    EV_DIALED = 3'h1,
    EV_RINGBACK = 3'h2,
    EV_BUSY = 3'h3,
    EV_NO_CARRIER = 3'h4,
    EV_CONNECT = 3'h5,
    EV_CONNECT_1200 = 3'h6
  } mtcc_event_type;

  typedef enum logic [1:0] {
    PROTO_NONE = 2'h0,
    PROTO_FSK300 = 2'h1,
    PROTO_DPSK1200 = 2'h2,
    PROTO_QAM2400 = 2'h3
  } mtcc_proto_type;

  // Bit 4 flags a valid hex digit, bits 3:0 its value
  function automatic logic [4:0] mtcc_hex_nibble(input logic [7:0] ch);
    logic [4:0] r;
    r = 5'h00;
    if (ch >= 8'h30 && ch <= 8'h39) begin
      r = {1'b1, ch[3:0]};
    end else if ((ch >= 8'h41 && ch <= 8'h46) || (ch >= 8'h61 && ch <= 8'h66)) begin
      r = {1'b1, 4'(ch[3:0] + 4'h9)};
    end
    return r;
  endfunction : mtcc_hex_nibble

  function automatic logic [7:0] mtcc_nibble_char(input logic [3:0] n);
    return (n < 4'hA) ? 8'(8'h30 + {4'h0, n}) : 8'(8'h37 + {4'h0, n});
  endfunction : mtcc_nibble_char

  function automatic logic [7:0] mtcc_event_char(input mtcc_event_type ev);
    logic [7:0] c;
    c = CH_NO_CARRIER;
    case (ev)
      EV_DIAL_TONE: c = CH_DIAL_TONE;
      EV_DIALED: c = CH_DIALED;
      EV_RINGBACK: c = CH_RINGBACK;
      EV_BUSY: c = CH_BUSY;
      EV_CONNECT: c = CH_CONNECT;
      EV_CONNECT_1200: c = CH_CONNECT_1200;
      default: c = CH_NO_CARRIER;
    endcase
    return c;
  endfunction : mtcc_event_char

endpackage : mtcc_pkg

// ---- rtl/mtcc_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides and a fill level
`timescale 1ns/100ps
module mtcc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_check
    $error("mtcc_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [$clog2(DEPTH+1)-1:0] count_reg;
  wire push = ce && in_valid && in_ready;
  wire pop = ce && out_valid && out_ready;

  assign in_ready = (count_reg != ($clog2(DEPTH+1))'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign level = count_reg;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      wr_ptr_reg <= push ? AW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
      rd_ptr_reg <= pop ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
      count_reg <= count_reg + push - pop;
    end
  end

endmodule : mtcc_fifo

// ---- rtl/mtcc_modem_ctl.sv ----
// Modem test and call control: command parser, test registers, progress codes, data mode
`timescale 1ns/100ps
module mtcc_modem_ctl
  import mtcc_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] host_rx_data,
  input wire logic host_rx_valid,
  output logic cts,
  output logic [7:0] host_tx_data,
  output logic host_tx_valid,
  input wire logic host_tx_ready,
  output logic [7:0] modem_tx_data,
  output logic modem_tx_valid,
  input wire logic modem_tx_ready,
  input wire logic [7:0] modem_rx_data,
  input wire logic modem_rx_valid,
  output logic modem_rx_ready,
  input wire logic call_evt_valid,
  input wire mtcc_event_type call_evt_code,
  input wire logic link_frame_ok,
  input wire logic [3:0] line_side_revision,
  input wire logic alert_event,
  output logic clock_output_pin,
  output logic hybrid_cancel_enable,
  output logic [7:0] dsp_mode_select,
  output logic [7:0] dsp_test_data_pattern,
  output logic test_tx_enable,
  output logic modulation_type_select,
  output logic test_originate,
  output logic guard_550,
  output logic guard_1800,
  output mtcc_proto_type speed_protocol,
  output logic alert_pin_out,
  output logic alert_pin_oe,
  output logic data_mode
);
  localparam int LW = $clog2(FIFO_DEPTH+1);

  if (FIFO_DEPTH < 4) begin : g_check
    $error("mtcc_modem_ctl: FIFO_DEPTH below 4 cannot cover the flow-control lag");
  end

  typedef enum logic [8:0] {
    P_IDLE = 9'h001, P_A = 9'h002, P_T = 9'h004, P_S = 9'h008, P_R1 = 9'h010,
    P_R2 = 9'h020, P_V1 = 9'h040, P_V2 = 9'h080, P_CR = 9'h100
  } mtcc_parse_type;

  mtcc_parse_type state_reg, state_next;
  logic [31:0] acc_reg;
  logic clock_output_pin_reg, cts_reg, tx_valid_reg, mtx_valid_reg, mrx_ready_reg;
  logic [7:0] tx_data_reg, mtx_data_reg;
  logic [7:0] addr_reg, val_reg, reply_reg;
  logic rd_reg, evt_pend_reg, data_mode_reg;
  mtcc_event_type evt_code_reg;
  logic [1:0] reply_cnt_reg;
  logic [7:0] speed_reg, alert_cfg_reg, pattern_reg, dspmode_reg, daactl_reg;
  logic [5:0] modctl_reg;
  mtcc_proto_type proto_reg;
  logic alert_reg, alert_oe_reg;

  logic [7:0] fifo_data;
  logic fifo_valid, fifo_in_ready, fifo_pop;
  logic [LW-1:0] fifo_level;

  // Host side flow: the FIFO absorbs bytes already in flight when cts drops
  mtcc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .in_data(host_rx_data),
    .in_valid(host_rx_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .level(fifo_level)
  );

  // Output slot arbitration
  wire slot_free = !tx_valid_reg || host_tx_ready;
  wire take_mrx = modem_rx_valid && mrx_ready_reg;
  wire send_evt = slot_free && evt_pend_reg && !take_mrx;
  wire send_reply = slot_free && !evt_pend_reg && reply_cnt_reg != 2'h0 && !take_mrx;
  wire pop_cmd = slot_free && !evt_pend_reg && reply_cnt_reg == 2'h0 && fifo_valid
                 && !data_mode_reg && !take_mrx;
  wire mtx_free = !mtx_valid_reg || modem_tx_ready;
  wire pop_data = data_mode_reg && fifo_valid && mtx_free;
  assign fifo_pop = pop_cmd || pop_data;

  // Command decode
  wire [4:0] hexv = mtcc_hex_nibble(fifo_data);
  wire is_hex = hexv[4];
  wire exec_fire = pop_cmd && state_reg == P_CR && fifo_data == CH_CR;
  wire exec_wr = exec_fire && !rd_reg;
  wire exec_rd = exec_fire && rd_reg;
  wire wr_speed = exec_wr && addr_reg == REG_SPEED;
  wire wr_alert = exec_wr && addr_reg == REG_ALERT;
  wire wr_modctl = exec_wr && addr_reg == REG_MODCTL;
  wire wr_dspmode = exec_wr && addr_reg == REG_DSPMODE;
  wire in_test_mode = dspmode_reg == DSP_MODE_TEST;
  wire [7:0] evt_char = mtcc_event_char(evt_code_reg);
  wire [3:0] reply_nib = (reply_cnt_reg == 2'h2) ? reply_reg[7:4] : reply_reg[3:0];
  wire [7:0] read_val =
      (addr_reg == REG_DAASTAT) ? 8'(link_frame_ok) << LINK_BIT :
      (addr_reg == REG_LINEINFO) ? {line_side_revision, 4'h0} :
      (addr_reg == REG_SPEED) ? speed_reg :
      (addr_reg == REG_ALERT) ? alert_cfg_reg :
      (addr_reg == REG_PATTERN) ? pattern_reg :
      (addr_reg == REG_DSPMODE) ? dspmode_reg :
      (addr_reg == REG_DAACTL) ? daactl_reg : 8'h00;
  wire mtcc_parse_type restart = (fifo_data == CH_A) ? P_A : P_IDLE;

  always_comb begin
    state_next = state_reg;
    if (pop_cmd) begin
      case (state_reg)
        P_IDLE: state_next = restart;
        P_A: state_next = (fifo_data == CH_T) ? P_T : restart;
        P_T: state_next = (fifo_data == CH_S) ? P_S : restart;
        P_S: state_next = is_hex ? P_R1 : restart;
        P_R1: state_next = is_hex ? P_R2 : restart;
        P_R2: state_next = (fifo_data == CH_EQ) ? P_V1 :
                           (fifo_data == CH_QUERY) ? P_CR : restart;
        P_V1: state_next = is_hex ? P_V2 : restart;
        P_V2: state_next = is_hex ? P_CR : restart;
        P_CR: state_next = restart;
        default: state_next = P_IDLE;
      endcase
    end
  end

  // Slot contents and data mode changes
  wire tx_load = take_mrx || send_evt || send_reply || pop_cmd;
  wire tx_valid_next = slot_free ? tx_load : 1'b1;
  wire [7:0] tx_data_next = take_mrx ? modem_rx_data : send_evt ? evt_char :
                            send_reply ? mtcc_nibble_char(reply_nib) :
                            pop_cmd ? fifo_data : tx_data_reg;
  wire is_connect = evt_code_reg == EV_CONNECT || evt_code_reg == EV_CONNECT_1200;
  wire data_mode_next = (send_evt && is_connect) ? 1'b1 :
                        (send_evt && evt_code_reg == EV_NO_CARRIER) ? 1'b0 : data_mode_reg;
  // A new event wins over the clear of the one being sent
  wire evt_pend_next = call_evt_valid || (evt_pend_reg && !send_evt);
  wire alert_next = (alert_cfg_reg == ALERT_ENABLE_VAL)
                    && (alert_event || (alert_reg && !wr_alert));
  wire [7:0] alert_cfg_next = wr_alert ? val_reg : alert_cfg_reg;

  wire [31:0] acc_next = acc_reg + CLOCK_OUTPUT_PIN_INC;
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_reg <= 32'h0000_0000;
      clock_output_pin_reg <= 1'b0;
    end else if (ce) begin
      acc_reg <= acc_next;
      clock_output_pin_reg <= acc_next[31];
    end
  end

  // Parser and output paths; echo loads each command character into the slot
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= P_IDLE;
      tx_valid_reg <= 1'b0;
      tx_data_reg <= 8'h00;
      mtx_valid_reg <= 1'b0;
      mtx_data_reg <= 8'h00;
      evt_pend_reg <= 1'b0;
      evt_code_reg <= EV_DIAL_TONE;
      data_mode_reg <= 1'b0;
      mrx_ready_reg <= 1'b0;
      cts_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      tx_valid_reg <= tx_valid_next;
      tx_data_reg <= tx_data_next;
      mtx_valid_reg <= pop_data || (mtx_valid_reg && !modem_tx_ready);
      mtx_data_reg <= pop_data ? fifo_data : mtx_data_reg;
      evt_pend_reg <= evt_pend_next;
      evt_code_reg <= call_evt_valid ? call_evt_code : evt_code_reg;
      // switch to data after a connect code
      data_mode_reg <= data_mode_next;
      mrx_ready_reg <= data_mode_next && !tx_valid_next && !evt_pend_next;
      // one slot of margin covers the registered lag of cts
      cts_reg <= fifo_level < LW'(FIFO_DEPTH - 1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      addr_reg <= 8'h00;
      val_reg <= 8'h00;
      rd_reg <= 1'b0;
      reply_reg <= 8'h00;
      reply_cnt_reg <= 2'h0;
    end else if (ce) begin
      addr_reg <= (pop_cmd && is_hex && (state_reg == P_S || state_reg == P_R1)) ?
                  {addr_reg[3:0], hexv[3:0]} : addr_reg;
      val_reg <= (pop_cmd && is_hex && (state_reg == P_V1 || state_reg == P_V2)) ?
                 {val_reg[3:0], hexv[3:0]} : val_reg;
      rd_reg <= (pop_cmd && state_reg == P_R2) ? (fifo_data == CH_QUERY) : rd_reg;
      reply_reg <= exec_rd ? read_val : reply_reg;
      reply_cnt_reg <= exec_rd ? 2'h2 : send_reply ? 2'(reply_cnt_reg - 1'b1) : reply_cnt_reg;
    end
  end

  // Register writes
  always_ff @(posedge clk) begin
    if (rst) begin
      speed_reg <= SPEED_RST;
      proto_reg <= PROTO_QAM2400;
      alert_cfg_reg <= ALERT_RST;
      pattern_reg <= PATTERN_RST;
      dspmode_reg <= DSPMODE_RST;
      daactl_reg <= DAACTL_RST;
      modctl_reg <= 6'h00;
      alert_reg <= 1'b0;
      alert_oe_reg <= 1'b0;
    end else if (ce) begin
      speed_reg <= wr_speed ? val_reg : speed_reg;
      if (wr_speed) begin
        proto_reg <= (val_reg == SPEED_QAM2400) ? PROTO_QAM2400 :
                     (val_reg == SPEED_DPSK1200) ? PROTO_DPSK1200 :
                     (val_reg == SPEED_FSK300) ? PROTO_FSK300 : PROTO_NONE;
      end
      pattern_reg <= (exec_wr && addr_reg == REG_PATTERN) ? val_reg : pattern_reg;
      dspmode_reg <= wr_dspmode ? val_reg : dspmode_reg;
      // hybrid enable lives in the control register
      daactl_reg <= (exec_wr && addr_reg == REG_DAACTL) ? val_reg : daactl_reg;
      // only documented bits kept, and only in mode 5
      if (wr_dspmode && val_reg != DSP_MODE_TEST) begin
        modctl_reg <= 6'h00;
      end else if (wr_modctl && in_test_mode) begin
        modctl_reg <= val_reg[5:0] & 6'h3D;
      end
      // sticky alert, an event in the clearing cycle still wins
      alert_cfg_reg <= alert_cfg_next;
      alert_reg <= alert_next;
      alert_oe_reg <= alert_cfg_next == ALERT_ENABLE_VAL;
    end
  end

  assign cts = cts_reg;
  assign host_tx_data = tx_data_reg;
  assign host_tx_valid = tx_valid_reg;
  assign modem_tx_data = mtx_data_reg;
  assign modem_tx_valid = mtx_valid_reg;
  assign modem_rx_ready = mrx_ready_reg;
  assign clock_output_pin = clock_output_pin_reg;
  assign hybrid_cancel_enable = daactl_reg[HYB_BIT];
  assign dsp_mode_select = dspmode_reg;
  assign dsp_test_data_pattern = pattern_reg;
  assign test_tx_enable = modctl_reg[MOD_TX_BIT];
  assign modulation_type_select = modctl_reg[MOD_QAM_BIT];
  assign test_originate = modctl_reg[MOD_ORIG_BIT];
  assign guard_550 = modctl_reg[MOD_G550_BIT];
  assign guard_1800 = modctl_reg[MOD_G1800_BIT];
  assign speed_protocol = proto_reg;
  assign alert_pin_out = alert_reg;
  assign alert_pin_oe = alert_oe_reg;
  assign data_mode = data_mode_reg;

  // Checks. Edge count over 1000 enabled cycles must match 245.76 per 1000.
  logic [9:0] win_cnt;
  logic [8:0] edge_cnt;
  logic clk_prev;
  wire rise = clock_output_pin_reg && !clk_prev;
  always_ff @(posedge clk) begin
    if (rst) begin
      win_cnt <= 10'h000;
      edge_cnt <= 9'h000;
      clk_prev <= 1'b0;
    end else if (ce) begin
      clk_prev <= clock_output_pin_reg;
      win_cnt <= (win_cnt == 10'd999) ? 10'h000 : 10'(win_cnt + 1'b1);
      edge_cnt <= (win_cnt == 10'd999) ? 9'h000 : 9'(edge_cnt + rise);
    end
  end

  property p_clock_output_pin_rate;
    @(posedge clk) disable iff (rst)
      (ce && win_cnt == 10'd999) |-> (9'(edge_cnt + rise) inside {9'd245, 9'd246});
  endproperty
  a_clock_output_pin_rate: assert property (p_clock_output_pin_rate) else $error("clock output rate wrong");

  property p_echo;
    @(posedge clk) disable iff (rst)
      (ce && pop_cmd) |=> (host_tx_valid && host_tx_data == $past(fifo_data));
  endproperty
  a_echo: assert property (p_echo) else $error("command character not echoed");

  property p_link_flag;
    @(posedge clk) disable iff (rst)
      (ce && exec_rd && addr_reg == REG_DAASTAT)
      |=> (reply_reg[LINK_BIT] == $past(link_frame_ok) && reply_cnt_reg == 2'h2);
  endproperty
  a_link_flag: assert property (p_link_flag) else $error("link flag read wrong");

  property p_revision;
    @(posedge clk) disable iff (rst)
      (ce && exec_rd && addr_reg == REG_LINEINFO) |=> reply_reg[7:4] == $past(line_side_revision);
  endproperty
  a_revision: assert property (p_revision) else $error("revision read wrong");

  property p_hybrid;
    @(posedge clk) disable iff (rst)
      (ce && exec_wr && addr_reg == REG_DAACTL) |=> hybrid_cancel_enable == $past(val_reg[2]);
  endproperty
  a_hybrid: assert property (p_hybrid) else $error("hybrid enable not applied");

  property p_mode_gate;
    @(posedge clk) disable iff (rst)
      (dspmode_reg != DSP_MODE_TEST) |-> !(test_tx_enable || modulation_type_select
        || test_originate || guard_550 || guard_1800);
  endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("test controls outside mode 5");

  property p_modctl;
    @(posedge clk) disable iff (rst)
      (ce && wr_modctl && in_test_mode) |=> (test_tx_enable == $past(val_reg[0])
        && modulation_type_select == $past(val_reg[2]) && test_originate == $past(val_reg[3])
        && guard_550 == $past(val_reg[4]) && guard_1800 == $past(val_reg[5]));
  endproperty
  a_modctl: assert property (p_modctl) else $error("modulation control mismatch");

  property p_speed;
    @(posedge clk) disable iff (rst)
      (ce && wr_speed && val_reg == SPEED_DPSK1200) |=> speed_protocol == PROTO_DPSK1200;
  endproperty
  a_speed: assert property (p_speed) else $error("speed select wrong");

  property p_connect;
    @(posedge clk) disable iff (rst)
      (ce && send_evt && is_connect) |=> (data_mode && host_tx_data == $past(evt_char));
  endproperty
  a_connect: assert property (p_connect) else $error("connect not followed by data");

  property p_cts;
    @(posedge clk) disable iff (rst) cts |-> fifo_in_ready;
  endproperty
  a_cts: assert property (p_cts) else $error("cts high while full");

  property p_alert_sticky;
    @(posedge clk) disable iff (rst)
      (ce && alert_pin_out && !wr_alert) |=> alert_pin_out;
  endproperty
  a_alert_sticky: assert property (p_alert_sticky) else $error("alert dropped");

  c_read: cover property (@(posedge clk) disable iff (rst) exec_rd);
  c_connect: cover property (@(posedge clk) disable iff (rst) send_evt && is_connect);
  c_cts_low: cover property (@(posedge clk) disable iff (rst) !cts ##1 cts);
  c_alert: cover property (@(posedge clk) disable iff (rst) alert_pin_out ##1 !alert_pin_out);

endmodule : mtcc_modem_ctl

// ---- dv/mtcc_host_model.sv ----
// Host microcontroller model: flow-controlled UART byte source and sink
`timescale 1ns/100ps
module mtcc_host_model (
  input wire logic clk,
  input wire logic cts,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready
);
  logic [7:0] txq[$];
  logic [7:0] rxq[$];
  logic [1:0] slow_reg = 2'h0;
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
  always @(negedge clk) begin
    slow_reg <= slow_reg + 2'h1;
    tx_ready <= slow_reg != 2'h3;
    if (cts && txq.size() > 0) begin
      rx_data <= txq.pop_front();
      rx_valid <= 1'b1;
    end else begin
      // Idle line shows a moving pattern so stale data never looks valid
      rx_data <= ~rx_data;
      rx_valid <= 1'b0;
    end
  end
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      rxq.push_back(tx_data);
    end
  end
endmodule : mtcc_host_model

// ---- dv/modem_test_and_call_control_tb_top.sv ----
// Self-checking bench for the modem test and call control block
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module modem_test_and_call_control_tb_top import mtcc_pkg::*;;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, host_rx_valid, cts, host_tx_valid, host_tx_ready;
  logic [7:0] host_rx_data, host_tx_data, modem_tx_data, dsp_mode_select, dsp_test_data_pattern;
  logic modem_tx_valid, modem_tx_ready = 1'b1, modem_rx_valid = 1'b0, modem_rx_ready;
  logic [7:0] modem_rx_data = 8'h00;
  logic call_evt_valid = 1'b0, link_frame_ok = 1'b1, alert_event = 1'b0, clock_output_pin;
  logic [3:0] line_side_revision = 4'hA;
  logic hybrid_cancel_enable, test_tx_enable, modulation_type_select, test_originate;
  logic guard_550, guard_1800, alert_pin_out, alert_pin_oe, data_mode;
  mtcc_event_type call_evt_code = EV_DIAL_TONE;
  mtcc_proto_type speed_protocol;
  int error_cnt = 0, tests_run = 0, cyc = 0;
  logic [4:0] mod5;
  assign mod5 = {guard_1800, guard_550, test_originate, modulation_type_select, test_tx_enable};
  mtcc_modem_ctl #(.FIFO_DEPTH(16)) dut (.clk(clk), .rst(rst), .ce(ce),
    .host_rx_data(host_rx_data), .host_rx_valid(host_rx_valid), .cts(cts),
    .host_tx_data(host_tx_data), .host_tx_valid(host_tx_valid), .host_tx_ready(host_tx_ready),
    .modem_tx_data(modem_tx_data), .modem_tx_valid(modem_tx_valid),
    .modem_tx_ready(modem_tx_ready), .modem_rx_data(modem_rx_data),
    .modem_rx_valid(modem_rx_valid), .modem_rx_ready(modem_rx_ready),
    .call_evt_valid(call_evt_valid), .call_evt_code(call_evt_code),
    .link_frame_ok(link_frame_ok), .line_side_revision(line_side_revision),
    .alert_event(alert_event), .clock_output_pin(clock_output_pin),
    .hybrid_cancel_enable(hybrid_cancel_enable), .dsp_mode_select(dsp_mode_select),
    .dsp_test_data_pattern(dsp_test_data_pattern), .test_tx_enable(test_tx_enable),
    .modulation_type_select(modulation_type_select), .test_originate(test_originate),
    .guard_550(guard_550), .guard_1800(guard_1800), .speed_protocol(speed_protocol),
    .alert_pin_out(alert_pin_out), .alert_pin_oe(alert_pin_oe), .data_mode(data_mode));
  mtcc_host_model h (.clk(clk), .cts(cts), .rx_data(host_rx_data), .rx_valid(host_rx_valid),
    .tx_data(host_tx_data), .tx_valid(host_tx_valid), .tx_ready(host_tx_ready));
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  task automatic wt(input int n);
    int k;
    k = 0;
    while (h.rxq.size() < n && k < 4000) begin
      @(negedge clk);
      k++;
    end
  endtask : wt
  task automatic rx(input logic [7:0] e);
    logic [7:0] g;
    g = (h.rxq.size() > 0) ? h.rxq.pop_front() : 8'hxx;
    `CHK(g, e)
  endtask : rx
  // Sends a command, checks its echo and leaves n reply bytes queued
  task automatic cmd(input string s, input int n);
    for (int i = 0; i < s.len(); i++) h.txq.push_back(8'(s[i]));
    wt(s.len() + n);
    for (int i = 0; i < s.len(); i++) rx(8'(s[i]));
  endtask : cmd
  task automatic t_clock();
    int n;
    logic p;
    n = 0;
    p = clock_output_pin;
    // 1000 cycles of 25 ns hold 245.76 output periods
    repeat (1000) begin
      @(negedge clk);
      n += (clock_output_pin && !p) ? 1 : 0;
      p = clock_output_pin;
    end
    `CHK(n >= 245 && n <= 246, 1'b1)
    // Clock enable low must freeze the output divider
    n = 0;
    ce = 1'b0;
    repeat (12) begin
      @(negedge clk);
      n += (clock_output_pin && !p) ? 1 : 0;
      p = clock_output_pin;
    end
    ce = 1'b1;
    `CHK(n, 0)
  endtask : t_clock
  task automatic t_mode5();
    cmd("ATSE5=3D\r", 0);
    `CHK(mod5, 5'h00)
    cmd("ATSE8=05\r", 0);
    `CHK(dsp_mode_select, DSP_MODE_TEST)
    cmd("ATSE5=3D\r", 0);
    `CHK(mod5, 5'h1F)
    cmd("ATSE5=C6\r", 0);
    `CHK(mod5, 5'h02)
    cmd("ATSE5=09\r", 0);
    `CHK(mod5, 5'h05)
    cmd("ATSE6=FF\r", 0);
    `CHK(dsp_test_data_pattern, 8'hFF)
  endtask : t_mode5
  task automatic t_speed_daa();
    logic [7:0] sp [3] = '{8'h06, 8'h02, 8'h01};
    for (int i = 0; i < 3; i++) begin
      cmd($sformatf("ATS07=%02X\r", sp[i]), 0);
      `CHK(speed_protocol, mtcc_proto_type'(3 - i))
    end
    cmd("ATSF1=00\r", 0);
    `CHK(hybrid_cancel_enable, 1'b0)
    cmd("ATSF2?\r", 2);
    rx("0");
    rx("8");
    link_frame_ok = 1'b0;
    cmd("ATSF2?\r", 2);
    rx("0");
    rx("0");
    link_frame_ok = 1'b1;
    cmd("ATSF8?\r", 2);
    rx("A");
    rx("0");
  endtask : t_speed_daa
  task automatic t_alert();
    alert_event = 1'b1;
    @(negedge clk);
    alert_event = 1'b0;
    @(negedge clk);
    `CHK(alert_pin_out, 1'b0)
    cmd("ATSE2=C0\r", 0);
    `CHK(alert_pin_oe, 1'b1)
    alert_event = 1'b1;
    @(negedge clk);
    alert_event = 1'b0;
    repeat (8) @(negedge clk);
    `CHK(alert_pin_out, 1'b1)
    cmd("ATSE2=C0\r", 0);
    `CHK(alert_pin_out, 1'b0)
  endtask : t_alert
  task automatic t_calls();
    string c;
    int k;
    c = "t,rbNcd";
    for (int i = 0; i < 7; i++) begin
      call_evt_code = mtcc_event_type'(i);
      call_evt_valid = 1'b1;
      @(negedge clk);
      call_evt_valid = 1'b0;
      wt(1);
      rx(8'(c[i]));
      `CHK(data_mode, i >= 5)
    end
    h.txq.push_back(8'h41);
    k = 0;
    while (!modem_tx_valid && k < 100) begin
      @(negedge clk);
      k++;
    end
    `CHK(modem_tx_data, 8'h41)
    modem_rx_data = 8'h5A;
    modem_rx_valid = 1'b1;
    while (!modem_rx_ready && k < 200) begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
    modem_rx_valid = 1'b0;
    wt(1);
    rx(8'h5A);
  endtask : t_calls
  // Stalled pump fills the FIFO; no byte may be lost once it drains
  task automatic t_flow();
    int k;
    modem_tx_ready = 1'b0;
    for (int i = 0; i < 20; i++) h.txq.push_back(8'(8'h10 + i));
    repeat (60) @(negedge clk);
    `CHK(cts, 1'b0)
    modem_tx_ready = 1'b1;
    for (int i = 0; i < 20; i++) begin
      k = 0;
      while (!modem_tx_valid && k < 100) begin
        @(negedge clk);
        k++;
      end
      `CHK(modem_tx_data, 8'(8'h10 + i))
      @(negedge clk);
    end
  endtask : t_flow
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    `CHK({hybrid_cancel_enable, speed_protocol, data_mode, alert_pin_oe}, 5'h1C)
    t_mode5();
    t_clock();
    t_speed_daa();
    t_alert();
    t_calls();
    t_flow();
    finish_test();
  end
endmodule : modem_test_and_call_control_tb_top
